// >>> prm_defines.svh
/*
 * Constants for the pump rotation manager: output count limits, reset values of the
 * rotation state and the configuration defaults.
 * Assumes it is included by its bare name by the package and the design modules.
 */
`ifndef PRM_DEFINES_SVH
`define PRM_DEFINES_SVH

// number of pump outputs and demand inputs
`define PRM_OUT_MAX 4
// accepted range of the controlled output count
`define PRM_NUM_OUT_MIN 3'h2
`define PRM_NUM_OUT_MAX 3'h4
// controlled output count after reset
`define PRM_NUM_OUT_RESET 3'h4
// rotation pointer after reset, zero based (output one)
`define PRM_PTR_RESET 2'h0
// pilot number shown for the reset pointer (output one)
`define PRM_PILOT_RESET 3'h1
// all outputs off
`define PRM_PUMPS_OFF 4'h0
// depth of the input synchroniser
`define PRM_SYNC_STAGES 2

`endif

// >>> prm_pkg.sv
/*
 * Types shared by the pump rotation manager modules.
 * Assumes prm_defines.svh is reachable on the include path.
 */
`include "prm_defines.svh"

package prm_pkg;

    // index of one pump output, zero based
    typedef logic [1:0] prm_idx_t;

    // all pin inputs that cross into the clock domain together
    typedef struct packed {
        logic [`PRM_OUT_MAX-1:0] demand;
        logic [`PRM_OUT_MAX-1:0] connected;
        logic [2:0] num_outputs;
        logic reinit_on_power_fail;
        logic power_restored;
    } prm_pins_t;

endpackage

// >>> prm_sync.sv
/*
 * Two flip-flop synchroniser for a bundle of pin levels.
 * Assumes each bit is a slow level; bits are not guaranteed to arrive in the same cycle.
 */
`timescale 1ns/100ps
`include "prm_defines.svh"

module prm_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // asynchronous levels in
    input wire logic [WIDTH-1:0] async_in,
    // synchronised levels out
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage [`PRM_SYNC_STAGES];

    // first stage feeds only the second stage
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage[0] <= '0;
            stage[1] <= '0;
        end else begin
            stage[0] <= async_in;
            stage[1] <= stage[0];
        end
    end

    assign sync_out = stage[1];

endmodule

// >>> prm_pump_rotation.sv
/*
 * Pump rotation manager: switches up to four pump outputs on and off so that the
 * number running follows the number of active demand inputs, rotating usage.
 * Assumes pin inputs are asynchronous levels and scan_tick is a one-cycle pulse
 * from logic on the same clock marking each controller scan.
 */
// Summary of operation
// - pumps on equal active demands, capped at controlled outputs, four at most
// - rising demand switches on next outputs upward, starting at pointer, after running ones
// - falling demand switches off the output that has run longest
// - on switch-off pointer becomes output following the one switched off
// - controlled output count accepts only two, three or four
// - with two controlled outputs, outputs three and four stay off
// - with three controlled outputs, output four stays off
// - unconnected demand inputs count as off
// - at initialization the pointer is output one
// - optional reset of pointer to output one after a power failure
// - current pointer is shown as an integer output
`timescale 1ns/100ps
`include "prm_defines.svh"

module prm_pump_rotation (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // scan pacing from controller logic
    input wire logic scan_tick,
    // demand pins and their connection straps
    input wire logic [`PRM_OUT_MAX-1:0] demand_in,
    input wire logic [`PRM_OUT_MAX-1:0] demand_connected,
    // configuration pins
    input wire logic [2:0] cfg_num_outputs,
    input wire logic cfg_reinit_on_power_fail,
    input wire logic power_restored,
    // pump drive and pilot number
    output logic [`PRM_OUT_MAX-1:0] pump_on,
    output logic [2:0] pilot_number
);

    prm_pkg::prm_pins_t pins_async;
    prm_pkg::prm_pins_t pins;
    logic [$bits(prm_pkg::prm_pins_t)-1:0] pins_sync_bits;
    logic [2:0] num_out;
    logic [2:0] cfg_hold;
    logic power_seen;
    prm_pkg::prm_idx_t ord [`PRM_OUT_MAX];
    logic [2:0] run_count;
    prm_pkg::prm_idx_t ptr;
    logic [2:0] active_count;
    logic [2:0] target;
    logic reconfig;
    logic power_event;
    logic step_up;
    logic step_down;
    prm_pkg::prm_idx_t last_on;
    prm_pkg::prm_idx_t next_idx;
    prm_pkg::prm_idx_t next_ptr;

    // wrap to output one past the highest controlled output
    function automatic prm_pkg::prm_idx_t wrap_next(input prm_pkg::prm_idx_t i,
                                                    input logic [2:0] n);
        logic [2:0] up;
        up = {1'b0, i} + 3'h1;
        if (up >= n) begin
            wrap_next = `PRM_PTR_RESET;
        end else begin
            wrap_next = up[1:0];
        end
    endfunction

    // gather pins and bring them into the clock domain
    assign pins_async = '{demand: demand_in, connected: demand_connected,
                          num_outputs: cfg_num_outputs,
                          reinit_on_power_fail: cfg_reinit_on_power_fail,
                          power_restored: power_restored};

    prm_sync #(
        .WIDTH($bits(prm_pkg::prm_pins_t))
    ) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .async_in(pins_async),
        .sync_out(pins_sync_bits)
    );

    assign pins = prm_pkg::prm_pins_t'(pins_sync_bits);

    // count connected active demands and cap at the controlled outputs
    always_comb begin
        active_count = 3'h0;
        for (int i = 0; i < `PRM_OUT_MAX; i++) begin
            active_count = active_count + {2'h0, pins.demand[i] & pins.connected[i]};
        end
        target = (active_count > num_out) ? num_out : active_count;
    end

    // decode events for this cycle
    assign reconfig = (pins.num_outputs == cfg_hold) &&
                      (pins.num_outputs >= `PRM_NUM_OUT_MIN) &&
                      (pins.num_outputs <= `PRM_NUM_OUT_MAX) &&
                      (pins.num_outputs != num_out);
    assign power_event = pins.power_restored & ~power_seen & pins.reinit_on_power_fail;
    assign step_up = scan_tick && (run_count < target);
    assign step_down = scan_tick && (run_count > target);
    assign last_on = ord[run_count[1:0] - 2'h1];
    assign next_idx = (run_count == 3'h0) ? ptr : wrap_next(last_on, num_out);
    assign next_ptr = wrap_next(ord[0], num_out);

    // last synchronised count; a count is taken only once it reads the same on two edges,
    // since its bits pass the synchroniser separately and may briefly mix old and new
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cfg_hold <= `PRM_NUM_OUT_RESET;
        end else begin
            cfg_hold <= pins.num_outputs;
        end
    end

    // controlled output count, changed only to an accepted value
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            num_out <= `PRM_NUM_OUT_RESET;
        end else if (reconfig) begin
            num_out <= pins.num_outputs;
        end
    end

    // edge memory for the power restore strobe
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            power_seen <= 1'b0;
        end else begin
            power_seen <= pins.power_restored;
        end
    end

    // age order of running outputs, oldest at entry zero
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            run_count <= 3'h0;
            for (int i = 0; i < `PRM_OUT_MAX; i++) begin
                ord[i] <= `PRM_PTR_RESET;
            end
        end else if (reconfig) begin
            run_count <= 3'h0;
        end else if (step_up) begin
            ord[run_count[1:0]] <= next_idx;
            run_count <= run_count + 3'h1;
        end else if (step_down) begin
            for (int i = 0; i < `PRM_OUT_MAX - 1; i++) begin
                ord[i] <= ord[i+1];
            end
            run_count <= run_count - 3'h1;
        end
    end

    // rotation pointer and its integer view
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ptr <= `PRM_PTR_RESET;
            pilot_number <= `PRM_PILOT_RESET;
        end else if (reconfig || power_event) begin
            ptr <= `PRM_PTR_RESET;
            pilot_number <= `PRM_PILOT_RESET;
        end else if (step_down) begin
            ptr <= next_ptr;
            pilot_number <= {1'b0, next_ptr} + 3'h1;
        end
    end

    // pump drive, one output changes per scan; a new controlled output count switches all off
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pump_on <= `PRM_PUMPS_OFF;
        end else if (reconfig) begin
            pump_on <= `PRM_PUMPS_OFF;
        end else if (step_up) begin
            pump_on[next_idx] <= 1'b1;
        end else if (step_down) begin
            pump_on[ord[0]] <= 1'b0;
        end
    end

    // checks on the rotation behaviour
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_grow;
        scan_tick && !reconfig && (run_count < target);
    endsequence

    sequence s_shrink;
        scan_tick && !reconfig && (run_count > target);
    endsequence

    property p_count_follows;
        s_grow |=> $countones(pump_on) == $past($countones(pump_on)) + 1;
    endproperty
    a_count_follows: assert property (p_count_follows)
        else $error("pump count did not rise by one");

    property p_first_at_pointer;
        s_grow and (run_count == 3'h0) |=> pump_on[$past(ptr)] && $countones(pump_on) == 1;
    endproperty
    a_first_at_pointer: assert property (p_first_at_pointer)
        else $error("first pump is not the pointer output");

    property p_oldest_off;
        s_shrink |=> !pump_on[$past(ord[0])] && $past(pump_on[ord[0]]);
    endproperty
    a_oldest_off: assert property (p_oldest_off)
        else $error("longest running pump not switched off");

    property p_pointer_after_off;
        s_shrink and !power_event |=>
            pilot_number == {1'b0, wrap_next($past(ord[0]), $past(num_out))} + 3'h1;
    endproperty
    a_pointer_after_off: assert property (p_pointer_after_off)
        else $error("pilot number does not follow switched off pump");

    property p_num_out_legal;
        num_out >= `PRM_NUM_OUT_MIN && num_out <= `PRM_NUM_OUT_MAX;
    endproperty
    a_num_out_legal: assert property (p_num_out_legal)
        else $error("controlled output count out of range");

    property p_two_outputs;
        num_out == 3'h2 && !$past(reconfig) |-> pump_on[3:2] == 2'h0;
    endproperty
    a_two_outputs: assert property (p_two_outputs)
        else $error("output three or four on with two controlled");

    property p_three_outputs;
        num_out == 3'h3 && !$past(reconfig) |-> !pump_on[3];
    endproperty
    a_three_outputs: assert property (p_three_outputs)
        else $error("output four on with three controlled");

    property p_unconnected_off;
        target <= $countones(pins.demand & pins.connected);
    endproperty
    a_unconnected_off: assert property (p_unconnected_off)
        else $error("unconnected demand counted");

    property p_power_reinit;
        power_event |=> pilot_number == `PRM_PILOT_RESET [*2];
    endproperty
    a_power_reinit: assert property (p_power_reinit)
        else $error("pointer not reset after power restore");

    property p_pointer_in_range;
        pilot_number >= 3'h1 && pilot_number <= num_out;
    endproperty
    a_pointer_in_range: assert property (p_pointer_in_range)
        else $error("pilot number beyond controlled outputs");

    property p_hold_between_scans;
        !scan_tick && !reconfig && !power_event |=> $stable(pump_on) && $stable(pilot_number);
    endproperty
    a_hold_between_scans: assert property (p_hold_between_scans)
        else $error("outputs moved without a scan tick");

    property p_init_state;
        $rose(rst_n) |-> pump_on == `PRM_PUMPS_OFF && pilot_number == `PRM_PILOT_RESET;
    endproperty
    a_init_state: assert property (p_init_state)
        else $error("outputs not at initial values after reset");

    property p_grow_keeps_pointer;
        s_grow and !power_event |=> $stable(pilot_number);
    endproperty
    a_grow_keeps_pointer: assert property (p_grow_keeps_pointer)
        else $error("pilot number moved on a switch-on");

    property p_one_step;
        scan_tick && !reconfig |=> $countones(pump_on ^ $past(pump_on)) <= 1;
    endproperty
    a_one_step: assert property (p_one_step)
        else $error("more than one pump changed in one scan");

    property p_hold_at_target;
        scan_tick && !reconfig && run_count == target |=> $stable(pump_on);
    endproperty
    a_hold_at_target: assert property (p_hold_at_target)
        else $error("pumps changed although count met demand");

    property p_shrink_by_one;
        s_shrink |=> $countones(pump_on) == $past($countones(pump_on)) - 1;
    endproperty
    a_shrink_by_one: assert property (p_shrink_by_one)
        else $error("pump count did not fall by one");

    property p_reconfig_clears;
        reconfig |=> pump_on == `PRM_PUMPS_OFF && pilot_number == `PRM_PILOT_RESET;
    endproperty
    a_reconfig_clears: assert property (p_reconfig_clears)
        else $error("new output count did not clear pumps and pointer");

    property p_power_keeps_pumps;
        power_event && !reconfig && !scan_tick |=> $stable(pump_on);
    endproperty
    a_power_keeps_pumps: assert property (p_power_keeps_pumps)
        else $error("power restore changed the pumps");

    property p_count_matches;
        run_count == $countones(pump_on);
    endproperty
    a_count_matches: assert property (p_count_matches)
        else $error("running count differs from pumps on");

endmodule

// >>> prm_sensor_model.sv
/*
 * Level sensor bank feeding the demand pins of the pump rotation manager.
 * Assumes the bench sets the count of wet sensors and the connection straps.
 */
`timescale 1ns/100ps

module prm_sensor_model (
    // sensor settings from the bench
    input wire logic [2:0] wet_count,
    input wire logic [3:0] strap,
    // demand pins
    output logic [3:0] demand,
    output logic [3:0] connected
);
    // sensors wet from input one upward; an open strap floats high, the worst case
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            demand[i] = strap[i] ? (3'(i) < wet_count) : 1'b1;
        end
        connected = strap;
    end
endmodule

// >>> prm_pump_rotation_tb.sv
/*
 * Self-checking bench for the pump rotation manager.
 * Assumes the sensor model drives the demand pins and nothing else drives the block.
 */
`timescale 1ns/100ps

module prm_pump_rotation_tb;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic scan_tick = 1'b0;
    logic [2:0] wet_count = 3'h0;
    logic [3:0] strap = 4'hf;
    logic [3:0] demand_in;
    logic [3:0] demand_connected;
    logic [2:0] cfg_num_outputs = 3'h4;
    logic cfg_reinit_on_power_fail = 1'b0;
    logic power_restored = 1'b0;
    logic [3:0] pump_on;
    logic [2:0] pilot_number;
    int miscompares = 0;
    int samples_checked = 0;

    // sensors on the demand side
    prm_sensor_model sensors (.wet_count(wet_count), .strap(strap), .demand(demand_in),
        .connected(demand_connected));

    // block under test
    prm_pump_rotation dut (.clock(clock), .rst_n(rst_n), .scan_tick(scan_tick),
        .demand_in(demand_in), .demand_connected(demand_connected),
        .cfg_num_outputs(cfg_num_outputs), .cfg_reinit_on_power_fail(cfg_reinit_on_power_fail),
        .power_restored(power_restored), .pump_on(pump_on), .pilot_number(pilot_number));

    // 50 MHz clock
    initial begin
        forever #10 clock = ~clock;
    end

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [3:0] ep, input logic [2:0] en);
        samples_checked++;
        if (pump_on !== ep || pilot_number !== en) begin
            miscompares++;
            $display("BAD t=%0t pumps %h exp %h pilot %h exp %h", $time, pump_on, ep,
                pilot_number, en);
        end
    endtask

    // one scan pulse, then the outputs it produced
    task automatic tick(input logic [3:0] ep, input logic [2:0] en);
        @(posedge clock);
        #2 scan_tick = 1'b1;
        @(posedge clock);
        #2 scan_tick = 1'b0;
        chk(ep, en);
    endtask

    // new pin levels, given time to pass the synchroniser and the count filter
    task automatic setup(input logic [2:0] w, input logic [3:0] s, input logic [2:0] n);
        @(posedge clock);
        #2 wet_count = w;
        strap = s;
        cfg_num_outputs = n;
        repeat (4) @(posedge clock);
        #2;
    endtask

    task automatic t_rotate();
        setup(3'h2, 4'hf, 3'h4);
        tick(4'h1, 3'h1);
        tick(4'h3, 3'h1);
        setup(3'h1, 4'hf, 3'h4);
        tick(4'h2, 3'h2);
        setup(3'h2, 4'hf, 3'h4);
        tick(4'h6, 3'h2);
        setup(3'h1, 4'hf, 3'h4);
        tick(4'h4, 3'h3);
        setup(3'h4, 4'hf, 3'h4);
        tick(4'hc, 3'h3);
        tick(4'hd, 3'h3);
        tick(4'hf, 3'h3);
        setup(3'h0, 4'hf, 3'h4);
        tick(4'hb, 3'h4);
        tick(4'h3, 3'h1);
        tick(4'h2, 3'h2);
        tick(4'h0, 3'h3);
        setup(3'h3, 4'hf, 3'h4);
        repeat (5) @(posedge clock);
        #2 chk(4'h0, 3'h3);
        $display("test rotate done");
    endtask

    task automatic t_two();
        setup(3'h4, 4'hf, 3'h2);
        chk(4'h0, 3'h1);
        tick(4'h1, 3'h1);
        tick(4'h3, 3'h1);
        tick(4'h3, 3'h1);
        setup(3'h1, 4'hf, 3'h2);
        tick(4'h2, 3'h2);
        setup(3'h2, 4'hf, 3'h2);
        tick(4'h3, 3'h2);
        setup(3'h0, 4'hf, 3'h2);
        tick(4'h1, 3'h1);
        tick(4'h0, 3'h2);
        $display("test two outputs done");
    endtask

    task automatic t_three();
        setup(3'h4, 4'hf, 3'h3);
        tick(4'h1, 3'h1);
        tick(4'h3, 3'h1);
        tick(4'h7, 3'h1);
        tick(4'h7, 3'h1);
        setup(3'h4, 4'hf, 3'h5);
        tick(4'h7, 3'h1);
        setup(3'h4, 4'h3, 3'h5);
        tick(4'h6, 3'h2);
        $display("test three outputs done");
    endtask

    task automatic t_power();
        @(posedge clock);
        #2 power_restored = 1'b1;
        repeat (4) @(posedge clock);
        #2 chk(4'h6, 3'h2);
        power_restored = 1'b0;
        cfg_reinit_on_power_fail = 1'b1;
        repeat (4) @(posedge clock);
        #2 power_restored = 1'b1;
        repeat (4) @(posedge clock);
        #2 chk(4'h6, 3'h1);
        $display("test power done");
    endtask

    // pointer moved off output one, then a reset in mid-run
    task automatic t_reset();
        setup(3'h1, 4'hf, 3'h3);
        tick(4'h4, 3'h3);
        @(posedge clock);
        #2 rst_n = 1'b0;
        @(posedge clock);
        #2 rst_n = 1'b1;
        chk(4'h0, 3'h1);
        repeat (5) @(posedge clock);
        tick(4'h1, 3'h1);
        $display("test reset done");
    endtask

    // cut a hang short
    initial begin
        repeat (3000) @(posedge clock);
        miscompares++;
        give_verdict();
    end

    // main sequence
    initial begin
        repeat (20) @(posedge clock);
        #2 rst_n = 1'b1;
        chk(4'h0, 3'h1);
        repeat (4) @(posedge clock);
        t_rotate();
        t_two();
        t_three();
        t_power();
        t_reset();
        give_verdict();
    end
endmodule
